// ==== hdl/e1rx_pkg.sv ====
// package: register map, field layout, reset values and types of the receive config bank
package e1rx_pkg;

	//////////////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses on the host register port)
	localparam logic [7:0] ADDR_TADDR = 8'h25;
	localparam logic [7:0] ADDR_TDATA = 8'h26;
	localparam logic [7:0] ADDR_ATTEN = 8'h27;
	localparam logic [7:0] ADDR_RXC0  = 8'h28;
	localparam logic [7:0] ADDR_RXC1  = 8'h29;
	localparam logic [7:0] ADDR_RXC2  = 8'h2A;
	localparam logic [7:0] ADDR_MNT0  = 8'h2B;
	localparam logic [7:0] ADDR_MNT1  = 8'h2C;
	localparam logic [7:0] ADDR_STAT  = 8'h38;
	localparam logic [7:0] ADDR_MEAS  = 8'h39;

	//////////////////////////////////////////////////////////////////////////////
	// writable bits of each register; all others read zero
	localparam logic [7:0] MASK_TADDR = 8'hFF;
	localparam logic [7:0] MASK_TDATA = 8'h7F;
	localparam logic [7:0] MASK_ATTEN = 8'h3F;
	localparam logic [7:0] MASK_RXC0  = 8'h11;
	localparam logic [7:0] MASK_RXC1  = 8'h5F;
	localparam logic [7:0] MASK_RXC2  = 8'h3F;
	localparam logic [7:0] MASK_MNT0  = 8'h60;
	localparam logic [7:0] MASK_MNT1  = 8'h10;

	// reset values
	localparam logic [7:0] RST_TADDR = 8'h00;
	localparam logic [7:0] RST_TDATA = 8'h00;
	localparam logic [7:0] RST_ATTEN = 8'h00;
	localparam logic [7:0] RST_RXC0  = 8'h00;
	localparam logic [7:0] RST_RXC1  = 8'h15;
	localparam logic [7:0] RST_RXC2  = 8'h18;
	localparam logic [7:0] RST_MNT0  = 8'h00;
	localparam logic [7:0] RST_MNT1  = 8'h00;

	//////////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int TADDR_EN_B  = 7;
	localparam int TADDR_RD_B  = 6;
	localparam int ATN_PEAK_B  = 5;
	localparam int ATN_LIMIT_B = 4;
	localparam int ATN_EN_B    = 3;
	localparam int ATN_DP_LO   = 1;
	localparam int ATN_BW_B    = 0;
	localparam int RXC0_OFF_B  = 4;
	localparam int RXC0_AMI_B  = 0;
	localparam int RXC1_EQ_B   = 6;
	localparam int RXC1_THR_LO = 0;
	localparam int RXC2_SLC_LO = 4;
	localparam int RXC2_WIN_LO = 2;
	localparam int RXC2_GN_LO  = 0;
	localparam int MNT0_DLB_B  = 6;
	localparam int MNT0_SLB_B  = 5;
	localparam int MNT1_CRIT_B = 4;

	//////////////////////////////////////////////////////////////////////////////
	// decoded values and counts
	localparam logic [7:0]  DEPTH_128    = 8'h80;
	localparam logic [7:0]  DEPTH_64     = 8'h40;
	localparam logic [7:0]  DEPTH_32     = 8'h20;
	localparam logic [7:0]  MARGIN_128   = 8'h04;
	localparam logic [7:0]  MARGIN_64    = 8'h03;
	localparam logic [7:0]  MARGIN_32    = 8'h02;
	localparam logic [9:0]  CORNER_WIDE  = 10'h2A5;
	localparam logic [9:0]  CORNER_NARR  = 10'h057;
	localparam logic [5:0]  THR_BASE_DB  = 6'h04;
	localparam logic [5:0]  THR_MAX_DB   = 6'h30;
	localparam logic [4:0]  THR_MAX_CODE = 5'h16;
	localparam logic [6:0]  SLC_BASE_PCT = 7'h28;
	localparam logic [6:0]  SLC_STEP_PCT = 7'h0A;
	localparam logic [8:0]  WIN_BASE     = 9'h020;
	localparam logic [4:0]  GAIN_HIGH_DB = 5'h16;
	localparam logic [11:0] SIGLOSS_SHORT = 12'h020;
	localparam logic [11:0] SIGLOSS_LONG  = 12'h800;

	//////////////////////////////////////////////////////////////////////////////
	// types
	typedef enum logic [1:0] {
		SL_OK   = 2'b01,
		SL_LOST = 2'b10
	} e1rx_sloss_t;

	typedef struct packed {
		logic        attenEnable;
		logic [7:0]  attenDepth;
		logic        attenBwNarrow;
		logic [9:0]  attenCornerCHz;
		logic        attenWiden;
		logic        rxPowerDown;
		logic        amiDecode;
		logic        eqOn;
		logic        thrValid;
		logic [5:0]  thrDb;
		logic        signalLost;
		logic [6:0]  slicerPct;
		logic [8:0]  peakWindow;
		logic [4:0]  monGainDb;
		logic        digLoopOne;
		logic        sysLoop;
	} e1rx_cfg_t;

	typedef struct packed {
		logic [7:0]  tAddr;
		logic [7:0]  tData;
		logic [7:0]  atten;
		logic [7:0]  rxc0;
		logic [7:0]  rxc1;
		logic [7:0]  rxc2;
		logic [7:0]  mnt0;
		logic [7:0]  mnt1;
		logic [6:0]  measure;
		logic [11:0] lowCnt;
		e1rx_sloss_t lossSt;
		logic [7:0]  rdData;
		e1rx_cfg_t   cfg;
	} e1rx_state_t;

endpackage

// ==== hdl/e1rx_cfg_regs.sv ====
// receive path configuration register bank with attenuator monitor and signal loss detector
`timescale 1ns/100ps

module e1rx_cfg_regs
	import e1rx_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// host register port
	input  wire logic [7:0]         regAddr,
	input  wire logic [7:0]         regWrData,
	input  wire logic               regWr,
	input  wire logic               regRd,
	output logic [7:0]              regRdData,
	// receive datapath status
	input  wire logic [6:0]         ptrInterval,
	input  wire logic               bitStrobe,
	input  wire logic               lowLevel,
	// pulse template readout
	input  wire logic [5:0]         tmplRdAddr,
	output logic [6:0]              tmplRdData,
	// decoded configuration
	output e1rx_pkg::e1rx_cfg_t     rxCfg
);
	import e1rx_pkg::*;

	//////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [7:0] fDepth(input logic [1:0] dp);
		case (dp)
			2'b00:   fDepth = DEPTH_128;
			2'b01:   fDepth = DEPTH_64;
			default: fDepth = DEPTH_32;
		endcase
	endfunction

	function automatic logic [7:0] fMargin(input logic [1:0] dp);
		case (dp)
			2'b00:   fMargin = MARGIN_128;
			2'b01:   fMargin = MARGIN_64;
			default: fMargin = MARGIN_32;
		endcase
	endfunction

	function automatic logic [5:0] fThrDb(input logic [4:0] code);
		if (code >= THR_MAX_CODE) begin
			fThrDb = THR_MAX_DB;
		end else begin
			fThrDb = THR_BASE_DB + {code, 1'b0};
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	// state

	e1rx_state_t st_ff;
	e1rx_state_t nxt_st;
	logic [6:0]  tmplMem [0:63];
	logic [6:0]  tmplRd_ff;
	logic [6:0]  tmplHost_ff;

	logic        wrTAddr;
	logic        wrTData;
	logic        wrAtten;
	logic        wrRxc0;
	logic        wrRxc1;
	logic        wrRxc2;
	logic        wrMnt0;
	logic        wrMnt1;
	logic        wrMeas;
	logic        tmplWrite;
	logic [5:0]  tmplAddr;
	logic [7:0]  fill;
	logic [7:0]  depth;
	logic [7:0]  margin;
	logic        nearEdge;
	logic [6:0]  measBase;
	logic [11:0] lowNeed;

	assign wrTAddr  = regWr && (regAddr == ADDR_TADDR);
	assign wrTData  = regWr && (regAddr == ADDR_TDATA);
	assign wrAtten  = regWr && (regAddr == ADDR_ATTEN);
	assign wrRxc0   = regWr && (regAddr == ADDR_RXC0);
	assign wrRxc1   = regWr && (regAddr == ADDR_RXC1);
	assign wrRxc2   = regWr && (regAddr == ADDR_RXC2);
	assign wrMnt0   = regWr && (regAddr == ADDR_MNT0);
	assign wrMnt1   = regWr && (regAddr == ADDR_MNT1);
	assign wrMeas   = regWr && (regAddr == ADDR_MEAS);
	assign tmplAddr = st_ff.tAddr[5:0];

	// RAM is written only while access is enabled and the direction is write
	assign tmplWrite = wrTData && st_ff.tAddr[TADDR_EN_B] && !st_ff.tAddr[TADDR_RD_B];

	//////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		nxt_st = st_ff;

		// register writes, masked so reserved bits stay zero
		if (wrTAddr) begin
			nxt_st.tAddr = regWrData & MASK_TADDR;
		end
		if (wrTData) begin
			nxt_st.tData = regWrData & MASK_TDATA;
		end
		if (wrAtten) begin
			nxt_st.atten = regWrData & MASK_ATTEN;
		end
		if (wrRxc0) begin
			nxt_st.rxc0 = regWrData & MASK_RXC0;
		end
		if (wrRxc1) begin
			nxt_st.rxc1 = regWrData & MASK_RXC1;
		end
		if (wrRxc2) begin
			nxt_st.rxc2 = regWrData & MASK_RXC2;
			// a reserved gain code leaves the previous gain in place
			if (regWrData[RXC2_GN_LO+1]) begin
				nxt_st.rxc2[RXC2_GN_LO+:2] = st_ff.rxc2[RXC2_GN_LO+:2];
			end
		end
		if (wrMnt0) begin
			nxt_st.mnt0 = regWrData & MASK_MNT0;
		end
		if (wrMnt1) begin
			nxt_st.mnt1 = regWrData & MASK_MNT1;
		end

		// pointer interval measurement; a host clear restarts the peak from the interval of its own cycle
		measBase = wrMeas ? 7'h00 : st_ff.measure;
		if (!st_ff.atten[ATN_PEAK_B]) begin
			nxt_st.measure = ptrInterval;
		end else if (ptrInterval > measBase) begin
			nxt_st.measure = ptrInterval;
		end else begin
			nxt_st.measure = measBase;
		end

		// signal loss: count consecutive low-level bit intervals
		lowNeed = st_ff.mnt1[MNT1_CRIT_B] ? SIGLOSS_LONG : SIGLOSS_SHORT;
		if (st_ff.rxc0[RXC0_OFF_B]) begin
			// powered-down receiver holds the detector idle
			nxt_st.lowCnt = 12'h000;
			nxt_st.lossSt = SL_OK;
		end else if (bitStrobe) begin
			if (!lowLevel) begin
				nxt_st.lowCnt = 12'h000;
				nxt_st.lossSt = SL_OK;
			end else begin
				case (st_ff.lossSt)
					SL_OK: begin
						if (st_ff.lowCnt + 12'h001 >= lowNeed) begin
							nxt_st.lossSt = SL_LOST;
						end else begin
							nxt_st.lowCnt = st_ff.lowCnt + 12'h001;
						end
					end
					SL_LOST: begin
						nxt_st.lossSt = SL_LOST;
					end
					default: begin
						nxt_st.lossSt = SL_OK;
						nxt_st.lowCnt = 12'h000;
					end
				endcase
			end
		end

		// read data, valid in the cycle after the strobe
		nxt_st.rdData = 8'h00;
		if (regRd) begin
			case (regAddr)
				ADDR_TADDR: nxt_st.rdData = st_ff.tAddr;
				ADDR_TDATA: nxt_st.rdData = st_ff.tAddr[TADDR_RD_B] ? {1'b0, tmplHost_ff} : st_ff.tData;
				ADDR_ATTEN: nxt_st.rdData = st_ff.atten;
				ADDR_RXC0:  nxt_st.rdData = st_ff.rxc0;
				ADDR_RXC1:  nxt_st.rdData = st_ff.rxc1;
				ADDR_RXC2:  nxt_st.rdData = st_ff.rxc2;
				ADDR_MNT0:  nxt_st.rdData = st_ff.mnt0;
				ADDR_MNT1:  nxt_st.rdData = st_ff.mnt1;
				ADDR_STAT:  nxt_st.rdData = {6'h00, st_ff.cfg.attenWiden, st_ff.cfg.signalLost};
				ADDR_MEAS:  nxt_st.rdData = {1'b0, st_ff.measure};
				default:    nxt_st.rdData = 8'h00;
			endcase
		end

		// decoded configuration, taken from the next register values so it
		// changes in the same cycle as the register itself
		depth    = fDepth(nxt_st.atten[ATN_DP_LO+:2]);
		margin   = fMargin(nxt_st.atten[ATN_DP_LO+:2]);
		fill     = {1'b0, ptrInterval};
		nearEdge = (fill <= margin) || (fill >= depth - margin);

		nxt_st.cfg.attenEnable    = nxt_st.atten[ATN_EN_B];
		nxt_st.cfg.attenDepth     = depth;
		nxt_st.cfg.attenBwNarrow  = nxt_st.atten[ATN_BW_B];
		nxt_st.cfg.attenCornerCHz = nxt_st.atten[ATN_BW_B] ? CORNER_NARR : CORNER_WIDE;
		// widening only matters while the attenuator is in the path
		nxt_st.cfg.attenWiden     = nxt_st.atten[ATN_LIMIT_B] && nxt_st.atten[ATN_EN_B] && nearEdge;
		nxt_st.cfg.rxPowerDown    = nxt_st.rxc0[RXC0_OFF_B];
		nxt_st.cfg.amiDecode      = nxt_st.rxc0[RXC0_AMI_B];
		nxt_st.cfg.eqOn           = nxt_st.rxc1[RXC1_EQ_B];
		nxt_st.cfg.thrValid       = nxt_st.rxc1[RXC1_EQ_B];
		nxt_st.cfg.thrDb          = nxt_st.rxc1[RXC1_EQ_B] ? fThrDb(nxt_st.rxc1[RXC1_THR_LO+:5]) : 6'h00;
		nxt_st.cfg.signalLost     = (nxt_st.lossSt == SL_LOST);
		nxt_st.cfg.slicerPct      = 7'(SLC_BASE_PCT + SLC_STEP_PCT * nxt_st.rxc2[RXC2_SLC_LO+:2]);
		nxt_st.cfg.peakWindow     = 9'(WIN_BASE << nxt_st.rxc2[RXC2_WIN_LO+:2]);
		nxt_st.cfg.monGainDb      = nxt_st.rxc2[RXC2_GN_LO] ? GAIN_HIGH_DB : 5'h00;
		nxt_st.cfg.digLoopOne     = nxt_st.mnt0[MNT0_DLB_B];
		nxt_st.cfg.sysLoop        = nxt_st.mnt0[MNT0_SLB_B];
	end

	//////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_ff <= '0;
			st_ff.tAddr  <= RST_TADDR;
			st_ff.tData  <= RST_TDATA;
			st_ff.atten  <= RST_ATTEN;
			st_ff.rxc0   <= RST_RXC0;
			st_ff.rxc1   <= RST_RXC1;
			st_ff.rxc2   <= RST_RXC2;
			st_ff.mnt0   <= RST_MNT0;
			st_ff.mnt1   <= RST_MNT1;
			st_ff.lossSt <= SL_OK;
			st_ff.cfg.attenDepth     <= DEPTH_128;
			st_ff.cfg.attenCornerCHz <= CORNER_WIDE;
			st_ff.cfg.slicerPct      <= SLC_BASE_PCT + SLC_STEP_PCT;
			st_ff.cfg.peakWindow     <= WIN_BASE << 2;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// template RAM has no reset; contents are undefined until written
	always_ff @(posedge clk) begin
		if (tmplWrite) begin
			tmplMem[tmplAddr] <= regWrData[6:0];
		end
		tmplRd_ff   <= tmplMem[tmplRdAddr];
		tmplHost_ff <= tmplMem[tmplAddr];
	end

	assign regRdData  = st_ff.rdData;
	assign rxCfg      = st_ff.cfg;
	assign tmplRdData = tmplRd_ff;

	//////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_tmpl_write;
		tmplWrite |=> (tmplMem[$past(tmplAddr)] == $past(regWrData[6:0]));
	endproperty
	a_tmpl_write: assert property (p_tmpl_write) else $error("template RAM write lost");

	property p_live_meas;
		!st_ff.atten[ATN_PEAK_B] && !wrAtten |=> (st_ff.measure == $past(ptrInterval));
	endproperty
	a_live_meas: assert property (p_live_meas) else $error("live interval not tracked");

	property p_peak_hold;
		st_ff.atten[ATN_PEAK_B] && !wrMeas && (ptrInterval <= st_ff.measure) |=> $stable(st_ff.measure);
	endproperty
	a_peak_hold: assert property (p_peak_hold) else $error("peak value changed on smaller interval");

	property p_widen;
		st_ff.atten[ATN_LIMIT_B] && st_ff.atten[ATN_EN_B] && !wrAtten && (ptrInterval <= 7'h01)
			|=> rxCfg.attenWiden;
	endproperty
	a_widen: assert property (p_widen) else $error("bandwidth not widened near underflow");

	property p_depth;
		(rxCfg.attenDepth == DEPTH_128) == (st_ff.atten[ATN_DP_LO+:2] == 2'b00);
	endproperty
	a_depth: assert property (p_depth) else $error("depth decode wrong");

	property p_short_haul;
		!rxCfg.eqOn |-> (rxCfg.thrDb == 6'h00) && !rxCfg.thrValid;
	endproperty
	a_short_haul: assert property (p_short_haul) else $error("threshold used in short haul");

	property p_loss_32;
		!st_ff.mnt1[MNT1_CRIT_B] && !st_ff.rxc0[RXC0_OFF_B] && (st_ff.lowCnt == 12'h01F)
			&& bitStrobe && lowLevel && !wrMnt1 |=> rxCfg.signalLost;
	endproperty
	a_loss_32: assert property (p_loss_32) else $error("loss not declared after 32 intervals");

	property p_reserved_rd;
		regRd && (regAddr == ADDR_ATTEN) |=> (regRdData[7:6] == 2'b00);
	endproperty
	a_reserved_rd: assert property (p_reserved_rd) else $error("reserved bits read nonzero");

	property p_gain;
		(rxCfg.monGainDb == 5'h00) || (rxCfg.monGainDb == GAIN_HIGH_DB);
	endproperty
	a_gain: assert property (p_gain) else $error("monitor gain off the allowed set");

	property p_loop_one;
		wrMnt0 |=> (rxCfg.digLoopOne == $past(regWrData[MNT0_DLB_B]));
	endproperty
	a_loop_one: assert property (p_loop_one) else $error("loopback one not following bit");

	property p_atten_enable;
		wrAtten |=> (rxCfg.attenEnable == $past(regWrData[ATN_EN_B]));
	endproperty
	a_atten_enable: assert property (p_atten_enable) else $error("attenuator enable not following bit");

	property p_corner;
		wrAtten |=> (rxCfg.attenCornerCHz == ($past(regWrData[ATN_BW_B]) ? CORNER_NARR : CORNER_WIDE));
	endproperty
	a_corner: assert property (p_corner) else $error("transfer corner does not match bandwidth bit");

	property p_power_down;
		rxCfg.rxPowerDown |=> !rxCfg.signalLost && (st_ff.lowCnt == 12'h000);
	endproperty
	a_power_down: assert property (p_power_down) else $error("loss detector active while powered down");

	property p_line_code;
		wrRxc0 |=> (rxCfg.amiDecode == $past(regWrData[RXC0_AMI_B]));
	endproperty
	a_line_code: assert property (p_line_code) else $error("line code select not following bit");

	property p_equalizer_on;
		wrRxc1 |=> (rxCfg.eqOn == $past(regWrData[RXC1_EQ_B]));
	endproperty
	a_equalizer_on: assert property (p_equalizer_on) else $error("equalizer not following bit");

	property p_thr_range;
		rxCfg.eqOn |-> rxCfg.thrValid && (rxCfg.thrDb >= THR_BASE_DB) && (rxCfg.thrDb <= THR_MAX_DB) && !rxCfg.thrDb[0];
	endproperty
	a_thr_range: assert property (p_thr_range) else $error("long haul threshold off the 2 dB grid");

	property p_slicer;
		wrRxc2 |=> (rxCfg.slicerPct == 7'(SLC_BASE_PCT + SLC_STEP_PCT * $past(regWrData[RXC2_SLC_LO+:2])));
	endproperty
	a_slicer: assert property (p_slicer) else $error("slicer threshold decode wrong");

	property p_window;
		wrRxc2 |=> (rxCfg.peakWindow == 9'(WIN_BASE << $past(regWrData[RXC2_WIN_LO+:2])));
	endproperty
	a_window: assert property (p_window) else $error("observation window decode wrong");

	property p_sys_loop;
		wrMnt0 |=> (rxCfg.sysLoop == $past(regWrData[MNT0_SLB_B]));
	endproperty
	a_sys_loop: assert property (p_sys_loop) else $error("system loopback not following bit");

	c_loss: cover property (!rxCfg.signalLost ##1 rxCfg.signalLost);
	c_widen: cover property (rxCfg.attenWiden);
	c_peak: cover property (st_ff.atten[ATN_PEAK_B] && (ptrInterval > st_ff.measure));
	c_tmpl: cover property (tmplWrite);

endmodule

// ==== sim/tb_e1rx_cfg_regs.sv ====
// self-checking testbench for the receive path configuration register bank
`timescale 1ns/100ps

module tb_e1rx_cfg_regs;
	import e1rx_pkg::*;

	logic       clk;
	logic       sys_rst;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic       regWr;
	logic       regRd;
	logic [7:0] regRdData;
	logic [6:0] ptrInterval;
	logic       bitStrobe;
	logic       lowLevel;
	logic [5:0] tmplRdAddr;
	logic [6:0] tmplRdData;
	e1rx_cfg_t  rxCfg;
	int         miscompares;
	int         total_checks;
	logic [7:0] addrTab [6];
	logic [7:0] maskTab [6];
	logic [7:0] rstTab [6];
	logic [4:0] thrTab [5];
	logic [6:0] wPtr [8];
	logic       wExp [8];

	e1rx_cfg_regs u_e1rx_cfg_regs (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .ptrInterval(ptrInterval), .bitStrobe(bitStrobe),
		.lowLevel(lowLevel), .tmplRdAddr(tmplRdAddr), .tmplRdData(tmplRdData), .rxCfg(rxCfg));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr   <= a;
		regWrData <= d;
		regWr     <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		chk($sformatf("read %0h", a), {4'h0, exp}, {4'h0, regRdData});
	endtask

	task automatic setPtr(input logic [6:0] v);
		@(posedge clk);
		ptrInterval <= v;
		repeat (3) @(posedge clk);
		#1;
	endtask

	// strobes every other cycle; gaps must not break a run of low intervals
	task automatic strobes(input int n, input logic lvl);
		@(posedge clk);
		lowLevel <= lvl;
		repeat (n) begin
			@(posedge clk);
			bitStrobe <= 1'b1;
			@(posedge clk);
			bitStrobe <= 1'b0;
		end
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic test_done();
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// the full run needs about 4400 cycles
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		test_done();
	end

	initial begin
		sys_rst     = 1'b1;
		regAddr     = 8'h00;
		regWrData   = 8'h00;
		regWr       = 1'b0;
		regRd       = 1'b0;
		ptrInterval = 7'h00;
		bitStrobe   = 1'b0;
		lowLevel    = 1'b0;
		tmplRdAddr  = 6'h00;
		addrTab = '{ADDR_ATTEN, ADDR_RXC0, ADDR_RXC1, ADDR_RXC2, ADDR_MNT0, ADDR_MNT1};
		maskTab = '{MASK_ATTEN, MASK_RXC0, MASK_RXC1, MASK_RXC2, MASK_MNT0, MASK_MNT1};
		rstTab  = '{RST_ATTEN, RST_RXC0, RST_RXC1, RST_RXC2, RST_MNT0, RST_MNT1};
		thrTab  = '{5'h00, 5'h01, 5'h0A, 5'h15, 5'h1F};
		wPtr    = '{7'h02, 7'h03, 7'h1D, 7'h1E, 7'h04, 7'h05, 7'h7B, 7'h7C};
		wExp    = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk("attenDepth", 12'h080, {4'h0, rxCfg.attenDepth});
		chk("window", 12'h080, {3'h0, rxCfg.peakWindow});
		chk("slicer", 12'h032, {5'h00, rxCfg.slicerPct});
		chk("thrDb", 12'h000, {6'h00, rxCfg.thrDb});
		for (int i = 0; i < 6; i++) begin
			rd(addrTab[i], rstTab[i]);
			wr(addrTab[i], 8'hFF);
			rd(addrTab[i], (addrTab[i] == ADDR_RXC2) ? 8'h3C : maskTab[i]);
		end
		@(posedge clk);
		#1 chk("readIdle", 12'h000, {4'h0, regRdData});
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00);
		// all bits set: widen active with depth 32 and interval 0, loss held clear by power-down
		wr(ADDR_STAT, 8'hFF);
		rd(ADDR_STAT, 8'h02);
		for (int i = 0; i < 6; i++) begin
			wr(addrTab[i], 8'h00);
		end

		for (int d = 0; d < 4; d++) begin
			wr(ADDR_ATTEN, 8'h08 | 8'(d << 1) | 8'(d & 1));
			chk("attenDepth", (d == 0) ? 12'h080 : (d == 1) ? 12'h040 : 12'h020, {4'h0, rxCfg.attenDepth});
			chk("attenCorner", (d & 1) ? 12'h057 : 12'h2A5, {2'h0, rxCfg.attenCornerCHz});
			chk("attenBwNarrow", (d & 1) ? 12'h001 : 12'h000, {11'h000, rxCfg.attenBwNarrow});
			chk("attenEnable", 12'h001, {11'h000, rxCfg.attenEnable});
		end
		wr(ADDR_ATTEN, 8'h00);
		chk("attenEnable", 12'h000, {11'h000, rxCfg.attenEnable});

		wr(ADDR_RXC0, 8'h11);
		chk("powerDown", 12'h001, {11'h000, rxCfg.rxPowerDown});
		chk("amiDecode", 12'h001, {11'h000, rxCfg.amiDecode});
		wr(ADDR_RXC0, 8'h00);
		chk("powerDown", 12'h000, {11'h000, rxCfg.rxPowerDown});
		chk("amiDecode", 12'h000, {11'h000, rxCfg.amiDecode});

		foreach (thrTab[i]) begin
			wr(ADDR_RXC1, 8'h40 | {3'h0, thrTab[i]});
			chk("thrDb", (thrTab[i] >= 5'h16) ? 12'h030 : 12'h004 + {6'h00, thrTab[i], 1'b0}, {6'h00, rxCfg.thrDb});
			chk("eqOn", 12'h001, {11'h000, rxCfg.eqOn});
			chk("thrValid", 12'h001, {11'h000, rxCfg.thrValid});
		end
		wr(ADDR_RXC1, 8'h15);
		chk("thrDb", 12'h000, {6'h00, rxCfg.thrDb});
		chk("eqOn", 12'h000, {11'h000, rxCfg.eqOn});
		chk("thrValid", 12'h000, {11'h000, rxCfg.thrValid});

		for (int s = 0; s < 4; s++) begin
			logic [1:0] c;
			c = 2'(s);
			wr(ADDR_RXC2, {2'h0, c, c, 1'b0, c[0]});
			chk("slicer", 12'h028 + {8'h00, c} * 12'h00A, {5'h00, rxCfg.slicerPct});
			chk("window", 12'h020 << c, {3'h0, rxCfg.peakWindow});
			chk("monGain", c[0] ? 12'h016 : 12'h000, {7'h00, rxCfg.monGainDb});
		end
		wr(ADDR_RXC2, 8'h02);
		chk("monGain", 12'h016, {7'h00, rxCfg.monGainDb});
		rd(ADDR_RXC2, 8'h01);

		wr(ADDR_MNT0, 8'h40);
		chk("digLoopOne", 12'h001, {11'h000, rxCfg.digLoopOne});
		chk("sysLoop", 12'h000, {11'h000, rxCfg.sysLoop});
		wr(ADDR_MNT0, 8'h20);
		chk("digLoopOne", 12'h000, {11'h000, rxCfg.digLoopOne});
		chk("sysLoop", 12'h001, {11'h000, rxCfg.sysLoop});

		setPtr(7'h31);
		rd(ADDR_MEAS, 8'h31);
		setPtr(7'h12);
		rd(ADDR_MEAS, 8'h12);
		wr(ADDR_ATTEN, 8'h20);
		setPtr(7'h50);
		setPtr(7'h12);
		rd(ADDR_MEAS, 8'h50);
		setPtr(7'h60);
		rd(ADDR_MEAS, 8'h60);
		// a clear keeps the interval standing in its own cycle, so lower it first
		setPtr(7'h12);
		wr(ADDR_MEAS, 8'h00);
		rd(ADDR_MEAS, 8'h12);

		// margins hit exactly at the window edges for depth 32 then 128
		foreach (wPtr[i]) begin
			if (i == 0) wr(ADDR_ATTEN, 8'h1C);
			if (i == 4) wr(ADDR_ATTEN, 8'h18);
			setPtr(wPtr[i]);
			chk("attenWiden", {11'h000, wExp[i]}, {11'h000, rxCfg.attenWiden});
		end
		wr(ADDR_ATTEN, 8'h0C);
		setPtr(7'h02);
		chk("attenWiden", 12'h000, {11'h000, rxCfg.attenWiden});
		wr(ADDR_ATTEN, 8'h00);

		strobes(31, 1'b1);
		chk("signalLost", 12'h000, {11'h000, rxCfg.signalLost});
		strobes(1, 1'b1);
		chk("signalLost", 12'h001, {11'h000, rxCfg.signalLost});
		rd(ADDR_STAT, 8'h01);
		strobes(1, 1'b0);
		chk("signalLost", 12'h000, {11'h000, rxCfg.signalLost});
		wr(ADDR_MNT1, 8'h10);
		strobes(2047, 1'b1);
		chk("signalLost", 12'h000, {11'h000, rxCfg.signalLost});
		strobes(1, 1'b1);
		chk("signalLost", 12'h001, {11'h000, rxCfg.signalLost});
		wr(ADDR_RXC0, 8'h10);
		repeat (2) @(posedge clk);
		#1 chk("signalLost", 12'h000, {11'h000, rxCfg.signalLost});

		wr(ADDR_TADDR, 8'hAB);
		wr(ADDR_TDATA, 8'h55);
		@(posedge clk);
		tmplRdAddr <= 6'h2B;
		repeat (2) @(posedge clk);
		#1 chk("tmplRdData", 12'h055, {5'h00, tmplRdData});
		// with the enable bit low only the data register changes
		wr(ADDR_TADDR, 8'h2B);
		wr(ADDR_TDATA, 8'h1A);
		repeat (2) @(posedge clk);
		#1 chk("tmplRdData", 12'h055, {5'h00, tmplRdData});
		rd(ADDR_TDATA, 8'h1A);
		// read direction: the data port shows the RAM word and writes stay out of the RAM
		wr(ADDR_TADDR, 8'hEB);
		wr(ADDR_TDATA, 8'h22);
		rd(ADDR_TDATA, 8'h55);
		test_done();
	end

endmodule
